/* File: include/port_seg_pkg.sv */
// constants shared by the port latch and segment select logic
package port_seg_pkg;
	// ************************************************************
	// register addresses
	// ************************************************************
	localparam logic [15:0] ADDR_PORT0   = 16'hff00;
	localparam logic [15:0] ADDR_PORT8   = 16'hff08;
	localparam logic [15:0] ADDR_DIR0    = 16'hff20;
	localparam logic [15:0] ADDR_SEG_SEL = 16'hff58;

	// ************************************************************
	// widths and values after reset
	// ************************************************************
	localparam int          PORT0_BITS  = 4;
	localparam int          SEG_BITS    = 6;
	localparam logic [7:0]  SEG_SEL_RST = 8'h00;
	localparam logic [7:0]  DIR_RST     = 8'hff;
	localparam logic [7:0]  LATCH_RST   = 8'h00;
	localparam logic [7:0]  UNMAPPED_RD = 8'h00;
endpackage : port_seg_pkg

/* File: include/port_access_if.sv */
// write strobes and read values between the decoder and a latch port
interface port_access_if #(parameter int W = 4);
	logic         latchWr;
	logic         dirWr;
	logic [7:0]   wrData;
	logic [W-1:0] rdVal;
	logic [W-1:0] dirVal;
	logic [W-1:0] latchVal;

	modport ctl  (output latchWr, dirWr, wrData,
		input rdVal, dirVal, latchVal);
	modport port (input latchWr, dirWr, wrData,
		output rdVal, dirVal, latchVal);
endinterface : port_access_if

/* File: verilog/latch_port.sv */
// one i/o port: output latch, direction bits and pin synchroniser
module latch_port #(
	parameter int W = 4
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] pinIn,
	port_access_if.port       acc
);
	import port_seg_pkg::*;

	logic [W-1:0] latch_r;
	logic [W-1:0] dir_r;
	logic [W-1:0] pinMeta_r;
	logic [W-1:0] pinSync_r;

	// ************************************************************
	// latch and direction
	// ************************************************************
	// the latch takes every write whatever the direction bit says
	always_ff @(posedge core_clk) begin
		if (reset) begin
			latch_r <= LATCH_RST[W-1:0];
		end else if (acc.latchWr) begin
			latch_r <= acc.wrData[W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			dir_r <= DIR_RST[W-1:0];
		end else if (acc.dirWr) begin
			dir_r <= acc.wrData[W-1:0];
		end
	end

	// ************************************************************
	// pin synchroniser
	// ************************************************************
	always_ff @(posedge core_clk) begin
		pinMeta_r <= pinIn;
		pinSync_r <= pinMeta_r;
	end

	// input bits read the pin, output bits read the latch
	assign acc.rdVal    = (dir_r & pinSync_r) | (~dir_r & latch_r);
	assign acc.dirVal   = dir_r;
	assign acc.latchVal = latch_r;
endmodule : latch_port

/* File: verilog/port_segment_select.sv */
// cpu port with latch, and six input pins shared with segment outputs
// Behaviour
// - low six bits choose port or segment role
// - segment select clears to zero at reset
// - segment select takes bit and byte writes
// - output mode write loads latch, drives pins
// - latch holds value until next write
// - input mode write loads latch, pin unchanged
// - output mode read returns latch, unchanged
// - input mode read returns pins, latch unchanged
// - output mode modify works on latch, drives
// - input mode modify may alter latch only
// - bit operation is byte read-modify-write
// - direction 0 drives pin, 1 releases
// - direction registers reset to all ones
// - shared port is six-bit input only
module port_segment_select (
	input  wire logic                                core_clk,
	input  wire logic                                reset,
	input  wire logic [15:0]                         cpuAddr,
	input  wire logic                                cpuWr,
	input  wire logic [7:0]                          cpuWrData,
	input  wire logic                                cpuBitWr,
	input  wire logic [2:0]                          cpuBitSel,
	input  wire logic                                cpuBitVal,
	input  wire logic                                cpuRd,
	output logic      [7:0]                          cpuRdData,
	input  wire logic [port_seg_pkg::PORT0_BITS-1:0] port0PinIn,
	output logic      [port_seg_pkg::PORT0_BITS-1:0] port0PinOut,
	output logic      [port_seg_pkg::PORT0_BITS-1:0] port0PinOeN,
	input  wire logic [port_seg_pkg::SEG_BITS-1:0]   sharedPortPinIn,
	input  wire logic [port_seg_pkg::SEG_BITS-1:0]   segData,
	output logic      [port_seg_pkg::SEG_BITS-1:0]   segmentOutputLine,
	output logic      [port_seg_pkg::SEG_BITS-1:0]   segmentOutputOeN
);
	import port_seg_pkg::*;

	localparam int P0W = PORT0_BITS;
	localparam int SW  = SEG_BITS;

	port_access_if #(.W(P0W)) acc0 ();

	logic [SW-1:0] segSel_r;
	logic [SW-1:0] p8Meta_r;
	logic [SW-1:0] p8Sync_r;
	logic [7:0]    rdData_r;
	logic [P0W-1:0] pinOut_r;
	logic [P0W-1:0] pinOeN_r;
	logic [SW-1:0] segOut_r;
	logic [SW-1:0] segOeN_r;
	logic [7:0]    curVal;
	logic [7:0]    bitMask;
	logic [7:0]    wrByte;
	logic          anyWr;

	// ************************************************************
	// access decode
	// ************************************************************
	always_comb begin
		curVal = UNMAPPED_RD;
		unique case (cpuAddr)
			ADDR_PORT0: begin
				curVal = {{(8 - P0W){1'b0}}, acc0.rdVal};
			end
			ADDR_DIR0: begin
				curVal = {{(8 - P0W){1'b1}}, acc0.dirVal};
			end
			ADDR_PORT8: begin
				curVal = {{(8 - SW){1'b0}}, p8Sync_r};
			end
			ADDR_SEG_SEL: begin
				curVal = {{(8 - SW){1'b0}}, segSel_r};
			end
			default: begin
				curVal = UNMAPPED_RD;
			end
		endcase
	end

	// a bit operation reads the whole byte and writes it back, so
	// input-mode latch bits pick up the pin levels on the way
	assign bitMask = 8'h01 << cpuBitSel;
	assign wrByte  = !cpuBitWr ? cpuWrData :
		(cpuBitVal ? (curVal | bitMask) : (curVal & ~bitMask));
	assign anyWr   = cpuWr | cpuBitWr;

	assign acc0.latchWr = anyWr && (cpuAddr == ADDR_PORT0);
	assign acc0.dirWr   = anyWr && (cpuAddr == ADDR_DIR0);
	assign acc0.wrData  = wrByte;

	latch_port #(.W(P0W)) u_port0 (
		.core_clk (core_clk),
		.reset    (reset),
		.pinIn    (port0PinIn),
		.acc      (acc0)
	);

	// ************************************************************
	// segment function select
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			segSel_r <= SEG_SEL_RST[SW-1:0];
		end else if (anyWr && cpuAddr == ADDR_SEG_SEL) begin
			segSel_r <= wrByte[SW-1:0];
		end
	end

	// ************************************************************
	// read data and pin registers
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdData_r <= UNMAPPED_RD;
		end else if (cpuRd) begin
			rdData_r <= curVal;
		end
	end

	// port 8 has no latch: writes to it fall on nothing
	always_ff @(posedge core_clk) begin
		p8Meta_r <= sharedPortPinIn;
		p8Sync_r <= p8Meta_r;
	end

	// output ports come from flops; costs one cycle behind the latch
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pinOut_r <= LATCH_RST[P0W-1:0];
			pinOeN_r <= DIR_RST[P0W-1:0];
		end else begin
			pinOut_r <= acc0.latchVal;
			pinOeN_r <= acc0.dirVal;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			segOut_r <= '0;
			segOeN_r <= '1;
		end else begin
			segOut_r <= segData & segSel_r;
			segOeN_r <= ~segSel_r;
		end
	end

	assign cpuRdData         = rdData_r;
	assign port0PinOut       = pinOut_r;
	assign port0PinOeN       = pinOeN_r;
	assign segmentOutputLine = segOut_r;
	assign segmentOutputOeN  = segOeN_r;

	// ************************************************************
	// assertions
	// ************************************************************
	sequence s_seg_byte_wr;
		cpuWr && !cpuBitWr && cpuAddr == ADDR_SEG_SEL;
	endsequence

	sequence s_seg_bit_wr;
		cpuBitWr && cpuAddr == ADDR_SEG_SEL && cpuBitSel < 3'h6;
	endsequence

	property p_seg_reset;
		@(posedge core_clk) reset |=> segSel_r == 6'h00 ##1
			segmentOutputOeN == 6'h3f;
	endproperty
	a_seg_reset: assert property (p_seg_reset) else
		$error("segment select not cleared by reset");

	property p_seg_byte;
		@(posedge core_clk) disable iff (reset)
		s_seg_byte_wr |=> segSel_r == $past(cpuWrData[5:0]) ##1
			segmentOutputOeN == ~$past(cpuWrData[5:0], 2);
	endproperty
	a_seg_byte: assert property (p_seg_byte) else
		$error("byte write to segment select lost");

	property p_seg_bit;
		@(posedge core_clk) disable iff (reset)
		s_seg_bit_wr |=> segSel_r[$past(cpuBitSel)] == $past(cpuBitVal);
	endproperty
	a_seg_bit: assert property (p_seg_bit) else
		$error("bit write to segment select lost");

	property p_seg_rsvd;
		@(posedge core_clk) disable iff (reset)
		cpuRd && cpuAddr == ADDR_SEG_SEL |=> cpuRdData[7:6] == 2'h0;
	endproperty
	a_seg_rsvd: assert property (p_seg_rsvd) else
		$error("reserved select bits read nonzero");

	property p_latch_hold;
		@(posedge core_clk) disable iff (reset)
		!(anyWr && cpuAddr == ADDR_PORT0) ##1 !reset
			|=> $stable(port0PinOut);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else
		$error("port latch changed without a write");

	property p_out_read;
		@(posedge core_clk) disable iff (reset)
		cpuRd && cpuAddr == ADDR_PORT0 && acc0.dirVal == '0
			|=> cpuRdData[3:0] == $past(acc0.latchVal);
	endproperty
	a_out_read: assert property (p_out_read) else
		$error("output mode read not from latch");

	property p_dir_wr;
		@(posedge core_clk) disable iff (reset)
		cpuWr && !cpuBitWr && cpuAddr == ADDR_DIR0 |=> ##1
			port0PinOeN == $past(cpuWrData[3:0], 2);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else
		$error("direction bit does not steer driver");

	property p_dir_reset;
		@(posedge core_clk) reset |=> port0PinOeN == 4'hf;
	endproperty
	a_dir_reset: assert property (p_dir_reset) else
		$error("port not in input mode after reset");

	property p_in_write;
		@(posedge core_clk) disable iff (reset)
		cpuWr && !cpuBitWr && cpuAddr == ADDR_PORT0 &&
			acc0.dirVal == 4'hf |=> ##1 port0PinOeN == 4'hf &&
			port0PinOut == $past(cpuWrData[3:0], 2);
	endproperty
	a_in_write: assert property (p_in_write) else
		$error("input mode write not latched quietly");
endmodule : port_segment_select

/* File: verif/board_pins.sv */
// board circuitry model: resolves port 0 pins, feeds the input-only pins
module board_pins
	import port_seg_pkg::*;
(
	input  wire logic [PORT0_BITS-1:0] pinOut,
	input  wire logic [PORT0_BITS-1:0] pinOeN,
	input  wire logic [PORT0_BITS-1:0] extLevel,
	output logic      [PORT0_BITS-1:0] pinIn,
	input  wire logic                  boosterEnable,
	input  wire logic [SEG_BITS-1:0]   sharedLevel,
	output logic      [SEG_BITS-1:0]   sharedIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// pin resolution
	// ************************************************************
	// a released pin shows the board level, a driven one the device
	always_comb begin
		for (int i = 0; i < PORT0_BITS; i++) begin
			pinIn[i] = pinOeN[i] ? extLevel[i] : pinOut[i];
		end
	end
	// with the booster off the protection network pulls the shared
	// pins, so their level cannot be trusted: shown inverted here
	assign sharedIn = boosterEnable ? sharedLevel : ~sharedLevel;
endmodule : board_pins

/* File: verif/port_segment_select_tb.sv */
// self-checking bench for the port latch and segment select block
module port_segment_select_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import port_seg_pkg::*;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic        core_clk = 0, reset = 1, cpuWr = 0, cpuBitWr = 0;
	logic        cpuRd = 0, cpuBitVal = 0;
	logic        boosterEnable = 1;
	logic [15:0] cpuAddr = 16'h0000;
	logic [7:0]  cpuWrData = 8'h00, cpuRdData, d;
	logic [2:0]  cpuBitSel = 3'h0;
	logic [3:0]  pIn, pOut, pOeN, extLevel = 4'h6;
	logic [5:0]  sIn, segData = 6'h2b, segLine, segOeN;
	int          errTotal = 0, checkCount = 0;
	typedef struct {logic b; logic [15:0] a; logic [7:0] w, e;} row_t;
	row_t rows [8] = '{
		'{0, ADDR_SEG_SEL, 8'h05, 8'h05}, '{1, ADDR_SEG_SEL, 8'h0c, 8'h15},
		'{1, ADDR_SEG_SEL, 8'h02, 8'h11}, '{0, ADDR_SEG_SEL, 8'hff, 8'h3f},
		'{0, ADDR_SEG_SEL, 8'h00, 8'h00}, '{0, ADDR_DIR0, 8'h0a, 8'hfa},
		'{0, ADDR_PORT8, 8'h55, 8'h2d}, '{0, 16'hff30, 8'h77, 8'h00}};
	always #4 core_clk = ~core_clk;
	board_pins i_board (.pinOut(pOut), .pinOeN(pOeN), .extLevel(extLevel),
		.pinIn(pIn), .boosterEnable(boosterEnable), .sharedLevel(6'h2d),
		.sharedIn(sIn));
	port_segment_select i_dut (.core_clk(core_clk), .reset(reset),
		.cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuWrData(cpuWrData),
		.cpuBitWr(cpuBitWr), .cpuBitSel(cpuBitSel), .cpuBitVal(cpuBitVal),
		.cpuRd(cpuRd), .cpuRdData(cpuRdData), .port0PinIn(pIn),
		.port0PinOut(pOut), .port0PinOeN(pOeN), .sharedPortPinIn(sIn),
		.segData(segData), .segmentOutputLine(segLine),
		.segmentOutputOeN(segOeN));
	// ************************************************************
	// bus tasks and checks
	// ************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [15:0] a, input logic [7:0] w);
		tick(1);
		cpuAddr   = a;
		cpuWrData = w;
		cpuWr     = 1;
		tick(1);
		cpuWr = 0;
	endtask : wr
	task automatic bitWr(input logic [15:0] a, input logic [2:0] s,
		input logic v);
		tick(1);
		cpuAddr   = a;
		cpuBitSel = s;
		cpuBitVal = v;
		cpuBitWr  = 1;
		tick(1);
		cpuBitWr = 0;
	endtask : bitWr
	task automatic rd(input logic [15:0] a);
		tick(1);
		cpuAddr = a;
		cpuRd   = 1;
		tick(1);
		cpuRd = 0;
		d     = cpuRdData;
	endtask : rd
	task automatic chk(input string n, input logic [7:0] e, g);
		checkCount++;
		if (g !== e) begin
			errTotal++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wrapUp();
		if (errTotal == 0 && checkCount > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrapUp
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		tick(12);
		reset = 0;
		chk("pinOeN", 8'h0f, {4'h0, pOeN});
		chk("segOeN", 8'h3f, {2'h0, segOeN});
		// input mode: the latch takes the write, the pins stay released
		wr(ADDR_PORT0, 8'h0a);
		tick(2);
		chk("pinOeN", 8'h0f, {4'h0, pOeN});
		rd(ADDR_PORT0);
		chk("port read", 8'h06, {4'h0, d[3:0]});
		foreach (rows[i]) begin
			if (rows[i].b) begin
				bitWr(rows[i].a, rows[i].w[2:0], rows[i].w[3]);
			end else begin
				wr(rows[i].a, rows[i].w);
			end
			rd(rows[i].a);
			chk("table read", rows[i].e, d);
		end
		wr(ADDR_SEG_SEL, 8'h05);
		tick(2);
		chk("segOeN", 8'h3a, {2'h0, segOeN});
		chk("segLine", 8'h01, {2'h0, segLine});
		// pins 1:0 driven, 3:2 left to the board
		wr(ADDR_DIR0, 8'h0c);
		tick(2);
		chk("pinOut", 8'h02, {6'h0, pOut[1:0]});
		wr(ADDR_PORT0, 8'h09);
		tick(4);
		chk("pinOeN", 8'h0c, {4'h0, pOeN});
		chk("pinOut", 8'h01, {6'h0, pOut[1:0]});
		rd(ADDR_PORT0);
		chk("port read", 8'h05, {4'h0, d[3:0]});
		// bit op copies pin levels into the input-mode latch bits
		bitWr(ADDR_PORT0, 3'h0, 1'b0);
		tick(2);
		chk("pinOut", 8'h00, {6'h0, pOut[1:0]});
		wr(ADDR_DIR0, 8'h00);
		tick(4);
		rd(ADDR_PORT0);
		chk("latch", 8'h04, {4'h0, d[3:0]});
		bitWr(ADDR_PORT0, 3'h3, 1'b1);
		tick(2);
		chk("pinOut", 8'h0c, {4'h0, pOut});
		rd(ADDR_PORT0);
		chk("latch", 8'h0c, {4'h0, d[3:0]});
		// a second reset must restore the select and direction registers
		reset = 1;
		tick(2);
		reset = 0;
		rd(ADDR_SEG_SEL);
		chk("select", SEG_SEL_RST, d);
		rd(ADDR_DIR0);
		chk("dir", DIR_RST, d);
		wrapUp();
	end
	// a hang counts as a mismatch and still reaches the verdict
	initial begin
		repeat (5000) @(posedge core_clk);
		errTotal++;
		wrapUp();
	end
endmodule : port_segment_select_tb
